// *** ect_timer.v ***
// Eight-bit compare timer channel
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01: Internal source counts falling prescaler edges
// R02: External input counts rise, fall, or both
// R03: External count levels held 1.5/2.5 clocks
// R04: Match fires in final state, sets flag
// R05: Match drives output keep, low, high, toggle
// R06: Clear counter on match A or B
// R07: Clear select 11: external rising edge clears
// R08: External clear pulse held 1.5 clocks
// R09: Wrap flag set on FF to 00
// R10: Three enabled interrupt lines from flags
// R11: Priority match A, match B, wrap
// R12: Clear beats simultaneous counter write
// R13: Counter write beats simultaneous increment
// R14: Constant write suppresses simultaneous match
// R15: Coincident matches: toggle, high, low, keep
// R16: High-to-low source switch counts once
// R17: High source to stopped counts once
// R18: Internal/external switch may count once
// R19: Clear on A, select 0110 gives pulses
// R20: Output select pairs: B upper, A lower
// R21: Clear select decode none, A, B, external
// R22: Flags cleared by read-1 then write-0
// R23: Clock select 000/100 stop, 101-111 external
// R24: Interrupt lines are levels while enabled
`include "ect_defs.vh"
module ect_timer #(
   parameter CNT_W = `ECT_CNT_W
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [2:0] i_clock_select,
   input wire [1:0] i_prescale_pick,
   input wire [1:0] i_clear_select,
   input wire [3:0] i_output_select,
   input wire i_match_irq_a_enable,
   input wire i_match_irq_b_enable,
   input wire i_wrap_irq_enable,
   input wire i_ext_count_input,
   input wire i_ext_clear_input,
   input wire i_count_wr,
   input wire [CNT_W-1:0] i_count_wdata,
   input wire i_const_a_wr,
   input wire i_const_b_wr,
   input wire [CNT_W-1:0] i_const_wdata,
   input wire i_flags_rd,
   input wire i_flags_wr,
   input wire [2:0] i_flags_wdata,
   output wire [CNT_W-1:0] o_count_value,
   output wire [CNT_W-1:0] o_match_const_a,
   output wire [CNT_W-1:0] o_match_const_b,
   output wire o_match_flag_a,
   output wire o_match_flag_b,
   output wire o_wrap_flag,
   output wire o_timer_output,
   output wire o_match_irq_a,
   output wire o_match_irq_b,
   output wire o_wrap_irq,
   output reg [1:0] o_top_irq
);
   reg [`ECT_PRE_W-1:0] pre_r;
   reg src_lvl_r;
   reg clr_in_r;
   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   reg [CNT_W-1:0] const_a_r;
   reg [CNT_W-1:0] const_b_r;
   reg flag_a_r;
   reg flag_b_r;
   reg flag_w_r;
   reg [2:0] armed_r;
   reg out_r;
   reg out_nxt;
   reg src_lvl;
   reg cnt_pulse;
   reg clr;
   reg wrap;
   wire match_a;
   wire match_b;
   wire [1:0] act_a;
   wire [1:0] act_b;
   wire ext_clr_edge;
   wire [2:0] flags;

   // Selected source level (prescaler tap or external pin); stopped reads low so a high-to-stop change is a falling edge
   always @* begin
      case (i_clock_select)
         `ECT_CKS_INT1: src_lvl = i_prescale_pick[0] ? pre_r[`ECT_TAP_DIV2] :
                                   pre_r[`ECT_TAP_DIV8]; // R01
         `ECT_CKS_INT2: src_lvl = i_prescale_pick[0] ? pre_r[`ECT_TAP_DIV32] :
                                   pre_r[`ECT_TAP_DIV64]; // R01
         `ECT_CKS_INT3: src_lvl = i_prescale_pick[0] ? pre_r[`ECT_TAP_DIV256] :
                                   pre_r[`ECT_TAP_DIV1024]; // R01
         `ECT_CKS_EXT_RISE: src_lvl = i_ext_count_input; // R23
         `ECT_CKS_EXT_FALL: src_lvl = i_ext_count_input; // R23
         `ECT_CKS_EXT_BOTH: src_lvl = i_ext_count_input; // R23
         default: src_lvl = 1'b0; // R23
      endcase
   end

   // One stored level for every source, so switching sources is seen as an edge
   always @* begin
      case (i_clock_select)
         `ECT_CKS_EXT_RISE: cnt_pulse = ~src_lvl_r & src_lvl; // R02 R18
         `ECT_CKS_EXT_BOTH: cnt_pulse = src_lvl_r ^ src_lvl; // R02
         default: cnt_pulse = src_lvl_r & ~src_lvl; // R01 R02 R16 R17 R18
      endcase
   end

   // Match is the last state of the equal count, suppressed by a constant write
   assign match_a = cnt_pulse & (cnt_r == const_a_r) & ~i_const_a_wr; // R04 R14
   assign match_b = cnt_pulse & (cnt_r == const_b_r) & ~i_const_b_wr; // R04 R14
   assign ext_clr_edge = i_ext_clear_input & ~clr_in_r; // R07

   always @* begin
      case (i_clear_select)
         `ECT_CLR_MATCH_A: clr = match_a; // R06 R21
         `ECT_CLR_MATCH_B: clr = match_b; // R06 R21
         `ECT_CLR_EXT: clr = ext_clr_edge; // R07 R21
         default: clr = 1'b0; // R21
      endcase
      wrap = 1'b0;
      if (clr) begin
         cnt_nxt = `ECT_CNT_ZERO; // R12
      end else if (i_count_wr) begin
         cnt_nxt = i_count_wdata; // R13
      end else if (cnt_pulse) begin
         cnt_nxt = cnt_r + 1'b1;
         wrap = (cnt_r == `ECT_CNT_MAX); // R09
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   assign act_a = match_a ? i_output_select[1:0] : `ECT_OS_KEEP; // R20
   assign act_b = match_b ? i_output_select[3:2] : `ECT_OS_KEEP; // R20

   // Coincident matches resolve toggle over high over low over keep
   always @* begin
      if (act_a == `ECT_OS_TOGGLE || act_b == `ECT_OS_TOGGLE) begin
         out_nxt = ~out_r; // R05 R15
      end else if (act_a == `ECT_OS_HIGH || act_b == `ECT_OS_HIGH) begin
         out_nxt = 1'b1; // R05 R15 R19
      end else if (act_a == `ECT_OS_LOW || act_b == `ECT_OS_LOW) begin
         out_nxt = 1'b0; // R05 R15 R19
      end else begin
         out_nxt = out_r; // R05
      end
   end

   assign flags = {flag_w_r, flag_b_r, flag_a_r};

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         pre_r <= `ECT_PRE_ZERO;
         src_lvl_r <= 1'b0;
         clr_in_r <= 1'b0;
         cnt_r <= `ECT_CNT_ZERO;
         const_a_r <= `ECT_CONST_RST;
         const_b_r <= `ECT_CONST_RST;
         flag_a_r <= 1'b0;
         flag_b_r <= 1'b0;
         flag_w_r <= 1'b0;
         armed_r <= `ECT_FLAGS_NONE;
         out_r <= 1'b0;
      end else begin
         pre_r <= pre_r + `ECT_PRE_ONE;
         src_lvl_r <= src_lvl;
         clr_in_r <= i_ext_clear_input;
         cnt_r <= cnt_nxt;
         if (i_const_a_wr) begin
            const_a_r <= i_const_wdata; // R14
         end
         if (i_const_b_wr) begin
            const_b_r <= i_const_wdata; // R14
         end
         out_r <= out_nxt;
         // Set wins over a clear in the same cycle; only armed flags may clear
         flag_a_r <= match_a | (flag_a_r & ~(i_flags_wr & armed_r[0] & ~i_flags_wdata[0])); // R04 R22
         flag_b_r <= match_b | (flag_b_r & ~(i_flags_wr & armed_r[1] & ~i_flags_wdata[1])); // R04 R22
         flag_w_r <= wrap | (flag_w_r & ~(i_flags_wr & armed_r[2] & ~i_flags_wdata[2])); // R09 R22
         if (i_flags_wr) begin
            armed_r <= `ECT_FLAGS_NONE; // R22
         end else if (i_flags_rd) begin
            armed_r <= armed_r | flags; // R22
         end
      end
   end

   assign o_count_value = cnt_r;
   assign o_match_const_a = const_a_r;
   assign o_match_const_b = const_b_r;
   assign o_match_flag_a = flag_a_r;
   assign o_match_flag_b = flag_b_r;
   assign o_wrap_flag = flag_w_r;
   assign o_timer_output = out_r;
   assign o_match_irq_a = flag_a_r & i_match_irq_a_enable; // R10 R24
   assign o_match_irq_b = flag_b_r & i_match_irq_b_enable; // R10 R24
   assign o_wrap_irq = flag_w_r & i_wrap_irq_enable; // R10 R24

   always @* begin
      if (o_match_irq_a) begin
         o_top_irq = `ECT_IRQ_A; // R11
      end else if (o_match_irq_b) begin
         o_top_irq = `ECT_IRQ_B; // R11
      end else if (o_wrap_irq) begin
         o_top_irq = `ECT_IRQ_WRAP; // R11
      end else begin
         o_top_irq = `ECT_IRQ_NONE;
      end
   end
endmodule
`default_nettype wire

// *** ect_defs.vh ***
// Constants for the eight-bit compare timer
`ifndef ECT_DEFS_VH
`define ECT_DEFS_VH
`define ECT_CNT_W 8
`define ECT_PRE_W 11
`define ECT_CNT_ZERO 8'h00
`define ECT_CNT_MAX 8'hFF
`define ECT_CONST_RST 8'hFF
`define ECT_PRE_ZERO 11'h000
`define ECT_PRE_ONE 11'h001
`define ECT_FLAGS_NONE 3'h0
// Clock select codes
`define ECT_CKS_STOP0 3'h0
`define ECT_CKS_INT1 3'h1
`define ECT_CKS_INT2 3'h2
`define ECT_CKS_INT3 3'h3
`define ECT_CKS_STOP4 3'h4
`define ECT_CKS_EXT_RISE 3'h5
`define ECT_CKS_EXT_FALL 3'h6
`define ECT_CKS_EXT_BOTH 3'h7
// Prescaler tap positions (divide by 2^(tap+1))
`define ECT_TAP_DIV2 0
`define ECT_TAP_DIV8 2
`define ECT_TAP_DIV32 4
`define ECT_TAP_DIV64 5
`define ECT_TAP_DIV256 7
`define ECT_TAP_DIV1024 9
// Clear select codes
`define ECT_CLR_NONE 2'h0
`define ECT_CLR_MATCH_A 2'h1
`define ECT_CLR_MATCH_B 2'h2
`define ECT_CLR_EXT 2'h3
// Output select action codes
`define ECT_OS_KEEP 2'h0
`define ECT_OS_LOW 2'h1
`define ECT_OS_HIGH 2'h2
`define ECT_OS_TOGGLE 2'h3
// Highest pending interrupt codes
`define ECT_IRQ_NONE 2'h0
`define ECT_IRQ_A 2'h1
`define ECT_IRQ_B 2'h2
`define ECT_IRQ_WRAP 2'h3
`endif

// *** ect_pins.sv ***
// External count and clear source model
`timescale 1ns/100ps
`default_nettype none
module ect_pins (
   input wire logic i_ref_clk,
   output var logic o_cnt = 1'b0,
   output var logic o_clr = 1'b0
);
   // Three-clock levels give margin over the both-edge minimum
   task pulse(input int n);
      repeat (2 * n) begin
         repeat (3) @(posedge i_ref_clk);
         #1 o_cnt = !o_cnt;
      end
   endtask
   task clr();
      @(posedge i_ref_clk);
      #1 o_clr = 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1 o_clr = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** ect_props.sv ***
// Port checks for the compare timer
`timescale 1ns/100ps
`default_nettype none
module ect_props (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_clock_select,
   input wire logic [1:0] i_clear_select,
   input wire logic i_match_irq_a_enable,
   input wire logic i_wrap_irq_enable,
   input wire logic i_ext_clear_input,
   input wire logic i_count_wr,
   input wire logic i_const_a_wr,
   input wire logic [7:0] i_count_wdata,
   input wire logic [7:0] o_count_value,
   input wire logic [7:0] o_match_const_a,
   input wire logic o_match_flag_a,
   input wire logic o_wrap_flag,
   input wire logic o_match_irq_a,
   input wire logic o_match_irq_b,
   input wire logic o_wrap_irq,
   input wire logic [1:0] o_top_irq
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   a_wrap_sets_flag: assert property ($past(o_count_value) == 8'hFF && o_count_value == 8'h00
      && !$past(i_count_wr) && $past(i_clear_select) == 2'h0 && !$past(i_rst) |-> o_wrap_flag)
      else $error("wrap flag");
   a_irq_a_level: assert property (o_match_irq_a == (o_match_flag_a && i_match_irq_a_enable))
      else $error("irq a");
   a_irq_wrap_level: assert property (o_wrap_irq == (o_wrap_flag && i_wrap_irq_enable))
      else $error("irq wrap");
   a_top_irq_order: assert property (o_top_irq == (o_match_irq_a ? 2'h1 : o_match_irq_b ? 2'h2
      : o_wrap_irq ? 2'h3 : 2'h0)) else $error("top irq");
   a_flag_a_cause: assert property ($rose(o_match_flag_a) |->
      $past(o_count_value) == $past(o_match_const_a) && !$past(i_const_a_wr)) else $error("flag a");
   a_count_write_wins: assert property ($past(i_count_wr) && $past(i_clear_select) == 2'h0
      && !$past(i_rst) |-> o_count_value == $past(i_count_wdata)) else $error("count write");
   a_stop_holds: assert property ($past(i_clock_select) == 3'h0 && !$past(i_count_wr)
      && $past(i_clock_select, 2) == 3'h0 && $past(i_clear_select) != 2'h3 && !$past(i_rst)
      |-> $stable(o_count_value)) else $error("stopped count moved");
   a_ext_clear_zero: assert property ($past(i_ext_clear_input) && !$past(i_ext_clear_input, 2)
      && $past(i_clear_select) == 2'h3 && !$past(i_rst) |-> o_count_value == 8'h00)
      else $error("ext clear");
endmodule
bind ect_timer ect_props u_props (.*);
`default_nettype wire

// *** tb.sv ***
// Directed bench for the compare timer
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_match_irq_a_enable = 1'b0, i_match_irq_b_enable = 1'b0;
   logic i_wrap_irq_enable = 1'b0, i_count_wr = 1'b0, i_const_a_wr = 1'b0, i_const_b_wr = 1'b0;
   logic i_flags_rd = 1'b0, i_flags_wr = 1'b0;
   logic [2:0] i_clock_select = 3'h0, i_flags_wdata = 3'h0;
   logic [1:0] i_prescale_pick = 2'h1, i_clear_select = 2'h0;
   logic [3:0] i_output_select = 4'h0;
   logic [7:0] i_count_wdata = 8'h00, i_const_wdata = 8'h00;
   wire logic i_ext_count_input, i_ext_clear_input, o_match_flag_a, o_match_flag_b, o_wrap_flag;
   wire logic o_timer_output, o_match_irq_a, o_match_irq_b, o_wrap_irq;
   wire logic [7:0] o_count_value, o_match_const_a, o_match_const_b;
   wire logic [1:0] o_top_irq;
   wire logic [7:0] fl = {5'h00, o_wrap_flag, o_match_flag_b, o_match_flag_a};
   wire logic [7:0] irq = {3'h0, o_match_irq_a, o_match_irq_b, o_wrap_irq, o_top_irq};
   int n_mismatch = 0, compares = 0, cycles = 0;
   ect_timer DUT (.*);
   ect_pins P (.i_ref_clk(i_ref_clk), .o_cnt(i_ext_count_input), .o_clr(i_ext_clear_input));
   always #5 i_ref_clk = ~i_ref_clk;
   task print_verdict();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   task wcnt(input logic [7:0] d);
      i_count_wdata = d;
      i_count_wr = 1'b1;
      cyc(1);
      i_count_wr = 1'b0;
   endtask
   task wconst(input logic b, input logic [7:0] d);
      i_const_wdata = d;
      i_const_a_wr = !b;
      i_const_b_wr = b;
      cyc(1);
      i_const_a_wr = 1'b0;
      i_const_b_wr = 1'b0;
   endtask
   // Optional read arms the set flags, then one write
   task fclr(input logic rd);
      i_flags_rd = rd;
      cyc(1);
      i_flags_rd = 1'b0;
      i_flags_wr = 1'b1;
      cyc(1);
      i_flags_wr = 1'b0;
   endtask
   initial begin
      cyc(6);
      i_rst = 1'b0;
      cyc(1);
      chk("consts", 8'hFF, o_match_const_a & o_match_const_b);
      chk("flags", 8'h00, fl);
      // Any 20 edges hold exactly ten taps at divide by two
      i_clock_select = 3'h1;
      wcnt(8'hF0);
      cyc(20);
      chk("count", 8'hFA, o_count_value);
      cyc(12);
      chk("count", 8'h00, o_count_value);
      chk("flags", 8'h07, fl);
      i_wrap_irq_enable = 1'b1;
      #1;
      chk("irq", 8'h07, irq);
      i_match_irq_a_enable = 1'b1;
      #1;
      chk("irq", 8'h15, irq);
      fclr(1'b0);
      chk("flags", 8'h07, fl);
      i_flags_wdata = 3'h6;
      fclr(1'b1);
      chk("flags", 8'h06, fl);
      i_match_irq_b_enable = 1'b1;
      #1;
      chk("irq", 8'h0E, irq);
      i_clock_select = 3'h0;
      i_clear_select = 2'h1;
      i_output_select = 4'h6;
      wconst(1'b0, 8'h04);
      wconst(1'b1, 8'h02);
      i_clock_select = 3'h1;
      wcnt(8'h00);
      cyc(10);
      chk("out", 8'h01, {o_count_value[6:0], o_timer_output});
      cyc(6);
      chk("out", 8'h00, {7'h00, o_timer_output});
      i_output_select = 4'h7;
      wconst(1'b1, 8'h04);
      cyc(3);
      chk("out", 8'h01, {7'h00, o_timer_output});
      i_clear_select = 2'h0;
      for (int k = 4; k < 8; k++) begin
         i_clock_select = k[2:0];
         wcnt(8'h00);
         P.pulse(2);
         cyc(2);
         chk("ext", (k == 7) ? 8'h04 : (k == 4) ? 8'h00 : 8'h02, o_count_value);
      end
      i_clock_select = 3'h0;
      i_clear_select = 2'h3;
      wcnt(8'h33);
      P.clr();
      chk("clr", 8'h00, o_count_value);
      print_verdict();
   end
endmodule
`default_nettype wire
